// [core/icc_capture.sv]
/*
  Input capture channel top: register port, capture control, interrupt status and mask.
  Assumes timer values and idle indication come from logic on core_clk; capIn is a raw pin.
*/
// The placing of the registers and the plain strobed port were decided locally.
// Behaviour
// - enable runs channel; clear resets, blocks new interrupt events (pending status still drives irq)
// - idle_halt set pauses channel in idle
// - first_edge_select used only in mode 110
// - wide_capture picks 32-bit timer value
// - timer_select picks third or second timer
// - interrupt_rate: every 1st..4th capture
// - overflow_flag reads one after overflow
// - buffer_not_empty reads one while values remain
// - unimplemented control bits read zero
`timescale 1ns/1ns
module icc_capture (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [icc_pkg::ADDR_W-1:0] addr,
  input wire logic [icc_pkg::DATA_W-1:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [icc_pkg::DATA_W-1:0] rdData,
  input wire logic capIn,
  input wire logic idleMode,
  input wire logic [icc_pkg::HALF_W-1:0] timer2Val,
  input wire logic [icc_pkg::HALF_W-1:0] timer3Val,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  logic enable_r;
  logic idleHalt_r;
  logic firstEdge_r;
  logic wide_r;
  logic tmrSel_r;
  logic [1:0] rate_r;
  logic [2:0] mode_r;
  logic ovf_r;
  logic firstDone_r;
  logic [3:0] presc_r;
  logic [1:0] evtCnt_r;
  logic [icc_pkg::IRQ_W-1:0] istat_r;
  logic [icc_pkg::IRQ_W-1:0] imask_r;
  logic [icc_pkg::DATA_W-1:0] rdData_r;
  logic irq_r;

  logic rise;
  logic fall;
  icc_buf_if buf_if ();

  icc_edge_sync u_edge (
    .core_clk(core_clk),
    .rstn(rstn),
    .pinIn(capIn),
    .rise(rise),
    .fall(fall)
  );

  icc_capture_buf u_buf (
    .core_clk(core_clk),
    .rstn(rstn),
    .bus(buf_if.store)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // address decode

  wire hitCtrl = (addr == icc_pkg::OFF_CTRL);
  wire hitBuf = (addr == icc_pkg::OFF_BUF);
  wire hitIstat = (addr == icc_pkg::OFF_ISTAT);
  wire hitImask = (addr == icc_pkg::OFF_IMASK);
  wire wrCtrl = wrStrobe & hitCtrl;
  wire wrIstat = wrStrobe & hitIstat;
  wire wrImask = wrStrobe & hitImask;

  ////////////////////////////////////////////////////////////////////////////////
  // capture qualification

  wire running = enable_r & ~(idleHalt_r & idleMode);
  wire anyEdge = rise | fall;
  wire firstSel = firstEdge_r ? rise : fall;
  wire firstHit = firstDone_r ? anyEdge : firstSel;
  wire prescMode = (mode_r == icc_pkg::MODE_RISE4) | (mode_r == icc_pkg::MODE_RISE16);
  wire [3:0] prescLast = (mode_r == icc_pkg::MODE_RISE4) ? icc_pkg::PRESC4_LAST : icc_pkg::PRESC16_LAST;
  wire prescHit = rise & (presc_r == prescLast);
  wire modeHit = (mode_r == icc_pkg::MODE_ANY) ? anyEdge :
                 (mode_r == icc_pkg::MODE_FALL) ? fall :
                 (mode_r == icc_pkg::MODE_RISE) ? rise :
                 (mode_r == icc_pkg::MODE_RISE_ALT) ? rise :
                 prescMode ? prescHit :
                 (mode_r == icc_pkg::MODE_FIRST) ? firstHit : 1'b0;
  wire edgeHit = running & modeHit;

  // narrow capture zero-extends; wide capture puts the third timer in the high half
  wire [icc_pkg::HALF_W-1:0] narrowVal = tmrSel_r ? timer2Val : timer3Val;
  wire [icc_pkg::DATA_W-1:0] capValue = wide_r ? {timer3Val, timer2Val} : {16'h0000, narrowVal};

  // a capture into a full buffer is dropped so older unread values survive
  wire pushOk = edgeHit & ~buf_if.full;
  wire ovfEvt = edgeHit & buf_if.full;
  wire rateHit = edgeHit & (evtCnt_r == rate_r);
  wire popReq = rdStrobe & hitBuf & ~buf_if.empty;

  assign buf_if.push = pushOk;
  assign buf_if.pushData = capValue;
  assign buf_if.pop = popReq;
  assign buf_if.clear = ~enable_r;

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt status

  wire [icc_pkg::IRQ_W-1:0] evtVec = {ovfEvt, rateHit};
  wire [icc_pkg::IRQ_W-1:0] clrVec = wrIstat ? wrData[icc_pkg::IRQ_W-1:0] : '0;
  // set wins over a same-cycle write-one-to-clear
  wire [icc_pkg::IRQ_W-1:0] istatNxt = (istat_r & ~clrVec) | evtVec;
  wire [icc_pkg::IRQ_W-1:0] imaskNxt = wrImask ? wrData[icc_pkg::IRQ_W-1:0] : imask_r;
  wire irqNxt = |(istatNxt & imaskNxt);

  ////////////////////////////////////////////////////////////////////////////////
  // read mux

  logic [icc_pkg::DATA_W-1:0] ctrlRd;
  always_comb begin
    ctrlRd = '0;
    ctrlRd[icc_pkg::ENABLE_BIT] = enable_r;
    ctrlRd[icc_pkg::IDLE_HALT_BIT] = idleHalt_r;
    ctrlRd[icc_pkg::FIRST_EDGE_BIT] = firstEdge_r;
    ctrlRd[icc_pkg::WIDE_BIT] = wide_r;
    ctrlRd[icc_pkg::TMR_SEL_BIT] = tmrSel_r;
    ctrlRd[icc_pkg::RATE_HI:icc_pkg::RATE_LO] = rate_r;
    ctrlRd[icc_pkg::OVF_BIT] = ovf_r;
    ctrlRd[icc_pkg::BNE_BIT] = ~buf_if.empty;
    ctrlRd[icc_pkg::MODE_HI:icc_pkg::MODE_LO] = mode_r;
  end

  // empty buffer reads zero; unmapped offsets read zero
  wire [icc_pkg::DATA_W-1:0] rdMux = hitCtrl ? ctrlRd :
                                     hitBuf ? (buf_if.empty ? '0 : buf_if.popData) :
                                     hitIstat ? {30'h0000_0000, istat_r} :
                                     hitImask ? {30'h0000_0000, imask_r} : '0;

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  // configuration stays writable at any time; software should change it while disabled
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      enable_r <= icc_pkg::CTRL_RESET[icc_pkg::ENABLE_BIT];
      idleHalt_r <= icc_pkg::CTRL_RESET[icc_pkg::IDLE_HALT_BIT];
      firstEdge_r <= icc_pkg::CTRL_RESET[icc_pkg::FIRST_EDGE_BIT];
      wide_r <= icc_pkg::CTRL_RESET[icc_pkg::WIDE_BIT];
      tmrSel_r <= icc_pkg::CTRL_RESET[icc_pkg::TMR_SEL_BIT];
      rate_r <= icc_pkg::CTRL_RESET[icc_pkg::RATE_HI:icc_pkg::RATE_LO];
      mode_r <= icc_pkg::CTRL_RESET[icc_pkg::MODE_HI:icc_pkg::MODE_LO];
    end else if (wrCtrl) begin
      enable_r <= wrData[icc_pkg::ENABLE_BIT];
      idleHalt_r <= wrData[icc_pkg::IDLE_HALT_BIT];
      firstEdge_r <= wrData[icc_pkg::FIRST_EDGE_BIT];
      wide_r <= wrData[icc_pkg::WIDE_BIT];
      tmrSel_r <= wrData[icc_pkg::TMR_SEL_BIT];
      rate_r <= wrData[icc_pkg::RATE_HI:icc_pkg::RATE_LO];
      mode_r <= wrData[icc_pkg::MODE_HI:icc_pkg::MODE_LO];
    end
  end

  // channel state is held reset while disabled
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ovf_r <= 1'b0;
      firstDone_r <= 1'b0;
      presc_r <= '0;
      evtCnt_r <= '0;
    end else if (!enable_r) begin
      ovf_r <= 1'b0;
      firstDone_r <= 1'b0;
      presc_r <= '0;
      evtCnt_r <= '0;
    end else begin
      ovf_r <= ovf_r | ovfEvt;
      firstDone_r <= firstDone_r | (edgeHit & (mode_r == icc_pkg::MODE_FIRST));
      // restart after each prescaled hit so every 4th rise captures, not every 16th
      presc_r <= (running & prescMode & prescHit) ? 4'h0 :
                 (running & prescMode & rise) ? presc_r + 4'h1 : presc_r;
      evtCnt_r <= rateHit ? 2'h0 : (edgeHit ? evtCnt_r + 2'h1 : evtCnt_r);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      istat_r <= '0;
      imask_r <= '0;
      irq_r <= 1'b0;
      rdData_r <= '0;
    end else begin
      istat_r <= istatNxt;
      imask_r <= imaskNxt;
      irq_r <= irqNxt;
      rdData_r <= rdStrobe ? rdMux : '0;
    end
  end

  assign rdData = rdData_r;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_ctrlRead;
    rdStrobe && hitCtrl;
  endsequence

  sequence s_bufRead;
    rdStrobe && hitBuf && !buf_if.empty;
  endsequence

  // helper: edges counted since last capture interrupt event
  logic [2:0] chkCnt_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      chkCnt_r <= '0;
    end else if (!enable_r || rateHit) begin
      chkCnt_r <= '0;
    end else if (edgeHit) begin
      chkCnt_r <= chkCnt_r + 3'h1;
    end
  end

  a_disable_clears: assert property ($fell(enable_r) |=> buf_if.empty && !ovf_r)
    else $error("disable did not reset the channel");
  a_disabled_quiet: assert property (!enable_r |-> !buf_if.push && evtVec == '0)
    else $error("disabled channel captured or raised an event");
  a_idle_halt: assert property (idleHalt_r && idleMode |-> !buf_if.push)
    else $error("capture while halted in idle");
  a_first_edge: assert property (mode_r == icc_pkg::MODE_FIRST && !firstDone_r && firstEdge_r && fall |-> !edgeHit)
    else $error("first capture on wrong edge");
  a_wide_value: assert property (buf_if.push && wide_r |-> buf_if.pushData == {timer3Val, timer2Val})
    else $error("wide capture value wrong");
  a_timer_select: assert property (buf_if.push && !wide_r && !tmrSel_r |-> buf_if.pushData == {16'h0000, timer3Val})
    else $error("narrow capture took wrong timer");
  a_rate_count: assert property (rateHit |-> chkCnt_r == {1'b0, rate_r})
    else $error("capture interrupt at wrong event count");
  a_ovf_sets: assert property (edgeHit && buf_if.full |=> ovf_r ##1 (ovf_r || !enable_r))
    else $error("overflow flag not set or not held");
  a_bne_read: assert property (s_ctrlRead |=> rdData_r[icc_pkg::BNE_BIT] == !$past(buf_if.empty))
    else $error("buffer-not-empty reads wrong");
  a_reserved_zero: assert property (s_ctrlRead |=> (rdData_r & ~icc_pkg::CTRL_RD_MASK) == '0)
    else $error("unimplemented control bits not zero");
  a_capture_push: assert property (edgeHit && !buf_if.full |=> !buf_if.empty)
    else $error("qualified edge not stored");
  a_buf_oldest: assert property (s_bufRead |=> rdData_r == $past(buf_if.popData))
    else $error("buffer read did not return oldest value");

endmodule : icc_capture

// [core/icc_pkg.sv]
/*
  Constants shared by the input capture channel: register offsets, control field positions,
  capture mode codes, buffer shape and interrupt status layout.
  Assumes a byte-addressed register port with 32-bit words on aligned offsets.
*/
package icc_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;

  // register offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_BUF = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_ISTAT = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_IMASK = 4'hc;

  // capture_control field positions
  localparam int ENABLE_BIT = 15;
  localparam int IDLE_HALT_BIT = 13;
  localparam int FIRST_EDGE_BIT = 9;
  localparam int WIDE_BIT = 8;
  localparam int TMR_SEL_BIT = 7;
  localparam int RATE_HI = 6;
  localparam int RATE_LO = 5;
  localparam int OVF_BIT = 4;
  localparam int BNE_BIT = 3;
  localparam int MODE_HI = 2;
  localparam int MODE_LO = 0;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] CTRL_RD_MASK = 32'h0000_a3ff;

  // capture mode codes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_ANY = 3'h1;
  localparam logic [2:0] MODE_FALL = 3'h2;
  localparam logic [2:0] MODE_RISE = 3'h3;
  localparam logic [2:0] MODE_RISE4 = 3'h4;
  localparam logic [2:0] MODE_RISE16 = 3'h5;
  localparam logic [2:0] MODE_FIRST = 3'h6;
  localparam logic [2:0] MODE_RISE_ALT = 3'h7;
  localparam logic [3:0] PRESC4_LAST = 4'h3;
  localparam logic [3:0] PRESC16_LAST = 4'hf;

  // capture buffer
  localparam int BUF_DEPTH = 4;
  localparam int PTR_W = 2;
  localparam int CNT_W = 3;

  // interrupt status layout
  localparam int IRQ_W = 2;
  localparam int IST_CAPT = 0;
  localparam int IST_OVF = 1;

endpackage : icc_pkg

// [core/icc_buf_if.sv]
/*
  Link between the channel control logic and its capture buffer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface icc_buf_if;
  logic push;
  logic [icc_pkg::DATA_W-1:0] pushData;
  logic pop;
  logic [icc_pkg::DATA_W-1:0] popData;
  logic full;
  logic empty;
  logic clear;

  modport producer (output push, output pushData, output pop, output clear,
                    input popData, input full, input empty);
  modport store (input push, input pushData, input pop, input clear,
                 output popData, output full, output empty);
endinterface : icc_buf_if

// [core/icc_edge_sync.sv]
/*
  Two-stage synchroniser for the capture pin plus rising and falling edge pulses.
  Assumes the pin is asynchronous to core_clk and wider than two clock periods per level.
*/
`timescale 1ns/1ns
module icc_edge_sync (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic pinIn,
  output logic rise,
  output logic fall
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pinIn;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // edges are seen only after the second stage
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;

endmodule : icc_edge_sync

// [core/icc_capture_buf.sv]
/*
  Small first-in first-out store of captured timer values.
  Assumes the producer never pushes while full; clear wins over push and pop.
*/
`timescale 1ns/1ns
module icc_capture_buf (
  input wire logic core_clk,
  input wire logic rstn,
  icc_buf_if.store bus
);

  logic [icc_pkg::DATA_W-1:0] mem [icc_pkg::BUF_DEPTH];
  logic [icc_pkg::PTR_W-1:0] wrPtr_r;
  logic [icc_pkg::PTR_W-1:0] rdPtr_r;
  logic [icc_pkg::CNT_W-1:0] count_r;
  logic doPush;
  logic doPop;

  assign bus.full = (count_r == icc_pkg::CNT_W'(icc_pkg::BUF_DEPTH));
  assign bus.empty = (count_r == '0);
  assign bus.popData = mem[rdPtr_r];
  assign doPush = bus.push & ~bus.full;
  assign doPop = bus.pop & ~bus.empty;

  always_ff @(posedge core_clk) begin
    if (doPush) begin
      mem[wrPtr_r] <= bus.pushData;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else if (bus.clear) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_r + PTR_ONE(doPush);
      rdPtr_r <= rdPtr_r + PTR_ONE(doPop);
      count_r <= count_r + icc_pkg::CNT_W'(doPush) - icc_pkg::CNT_W'(doPop);
    end
  end

  function automatic logic [icc_pkg::PTR_W-1:0] PTR_ONE(input logic step);
    PTR_ONE = icc_pkg::PTR_W'(step);
  endfunction : PTR_ONE

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_count_bound: assert property (count_r <= icc_pkg::CNT_W'(icc_pkg::BUF_DEPTH))
    else $error("capture buffer count above depth");
  a_pop_order: assert property (doPop && !doPush && !bus.clear |=> rdPtr_r == $past(rdPtr_r) + 2'h1)
    else $error("pop did not advance to next oldest value");

endmodule : icc_capture_buf

// [dv/icc_far_model.sv]
/*
  Far-side model of the capture channel: the capture pin and the two general timers.
  Assumes the bench calls setPin and loadTimers; timers hold the loaded values.
*/
`timescale 1ns/1ns
module icc_far_model (
  input wire logic core_clk,
  output logic capIn,
  output logic [15:0] timer2Val,
  output logic [15:0] timer3Val
);
  initial begin
    capIn = 1'b0;
    timer2Val = 16'h0000;
    timer3Val = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin changes land just after an edge, like a real asynchronous source
  task automatic setPin(input logic v);
    @(posedge core_clk);
    capIn <= v;
  endtask : setPin

  // timers held still so the captured value is known exactly
  task automatic loadTimers(input logic [15:0] t2, input logic [15:0] t3);
    @(posedge core_clk);
    timer2Val <= t2;
    timer3Val <= t3;
  endtask : loadTimers
endmodule : icc_far_model

// [dv/input_capture_control_tb_top.sv]
/*
  Self-checking bench for the capture channel, driven over its register port.
  Assumes the far-side model and a 20 MHz core_clk.
*/
`timescale 1ns/1ns
`define CHECK(what, exp, got) \
  begin \
    testsRun++; \
    if ((got) !== (exp)) begin \
      failCount++; \
      $display("ERROR %s expected %h seen %h", what, exp, got); \
    end \
  end
module input_capture_control_tb_top;
  logic core_clk, rstn, wrStrobe, rdStrobe, idleMode, capIn, irq;
  logic [3:0] addr;
  logic [31:0] wrData, rdData, rd, c;
  logic [15:0] timer2Val, timer3Val;
  int failCount, testsRun, k, e;

  icc_capture icc_capture_i (.core_clk(core_clk), .rstn(rstn), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .capIn(capIn),
    .idleMode(idleMode), .timer2Val(timer2Val), .timer3Val(timer3Val), .irq(irq));
  icc_far_model icc_far_model_i (.core_clk(core_clk), .capIn(capIn), .timer2Val(timer2Val),
    .timer3Val(timer3Val));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] ctl(input logic en, idl, fe, wide, tsel, input logic [1:0] rate,
    input logic [2:0] mode);
    ctl = {16'h0000, en, 1'b0, idl, 3'h0, fe, wide, tsel, rate, 2'h0, mode};
  endfunction : ctl

  task automatic busWrite(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge core_clk);
    wrStrobe <= 1'b0;
  endtask : busWrite

  task automatic expectReg(input string what, input logic [3:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge core_clk);
    rdStrobe <= 1'b0;
    #1;
    rd = rdData;
    `CHECK(what, exp, rd)
  endtask : expectReg

  // six cycles covers sync, detect, push and the registered irq
  task automatic toggle;
    icc_far_model_i.setPin(~capIn);
    repeat (6) @(posedge core_clk);
    #1;
  endtask : toggle

  // one idle cycle always follows a disabling write
  task automatic disable_ch;
    busWrite(icc_pkg::OFF_CTRL, 32'h0);
  endtask : disable_ch

  task automatic wrapUp;
    if (failCount == 0 && testsRun > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrapUp

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    failCount++;
    wrapUp();
  end

  initial begin
    rstn = 1'b0; addr = 4'h0; wrData = 32'h0; wrStrobe = 1'b0; rdStrobe = 1'b0; idleMode = 1'b0;
    failCount = 0;
    testsRun = 0;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    expectReg("ctrl reset", icc_pkg::OFF_CTRL, 32'h0);
    expectReg("unmapped", 4'h2, 32'h0);
    busWrite(icc_pkg::OFF_CTRL, 32'hffff_ffff);
    expectReg("ctrl bits", icc_pkg::OFF_CTRL, 32'h0000_a3e7);
    disable_ch();
    // source selection: third timer, second timer, then both joined
    icc_far_model_i.loadTimers(16'h1234, 16'habcd);
    for (k = 0; k < 3; k++) begin
      c = ctl(1'b1, 1'b0, 1'b0, k == 2, k == 1, 2'h0, icc_pkg::MODE_RISE);
      busWrite(icc_pkg::OFF_CTRL, c);
      toggle();
      toggle();
      expectReg("bne set", icc_pkg::OFF_CTRL, c | 32'h8);
      expectReg("capture", icc_pkg::OFF_BUF, k == 0 ? 32'h0000_abcd : k == 1 ? 32'h0000_1234 : 32'habcd_1234);
      expectReg("bne clear", icc_pkg::OFF_CTRL, c);
      expectReg("empty pop", icc_pkg::OFF_BUF, 32'h0);
      disable_ch();
    end
    // first edge choice in mode 110
    for (k = 0; k < 2; k++) begin
      c = ctl(1'b1, 1'b0, k[0], 1'b0, 1'b0, 2'h0, icc_pkg::MODE_FIRST);
      busWrite(icc_pkg::OFF_CTRL, c);
      toggle();
      expectReg("first rise", icc_pkg::OFF_CTRL, c | {28'h0, k[0], 3'h0});
      toggle();
      expectReg("then fall", icc_pkg::OFF_CTRL, c | 32'h8);
      disable_ch();
    end
    // every interrupt rate code
    busWrite(icc_pkg::OFF_IMASK, 32'h1);
    for (k = 0; k < 4; k++) begin
      busWrite(icc_pkg::OFF_CTRL, ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, k[1:0], icc_pkg::MODE_ANY));
      for (e = 0; e <= k; e++) begin
        toggle();
        `CHECK("irq rate", e == k, irq)
      end
      disable_ch();
      busWrite(icc_pkg::OFF_ISTAT, 32'h1);
      expectReg("status clr", icc_pkg::OFF_ISTAT, 32'h0);
      `CHECK("irq clr", 1'b0, irq)
    end
    // overflow with the interrupt masked, then unmasked
    busWrite(icc_pkg::OFF_IMASK, 32'h0);
    c = ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, icc_pkg::MODE_ANY);
    busWrite(icc_pkg::OFF_CTRL, c);
    for (e = 0; e < 5; e++) toggle();
    expectReg("ovf set", icc_pkg::OFF_CTRL, c | 32'h18);
    expectReg("status", icc_pkg::OFF_ISTAT, 32'h3);
    `CHECK("irq masked", 1'b0, irq)
    busWrite(icc_pkg::OFF_IMASK, 32'h2);
    @(posedge core_clk);
    #1;
    `CHECK("irq ovf", 1'b1, irq)
    for (e = 0; e < 4; e++) expectReg("drain", icc_pkg::OFF_BUF, 32'h0000_abcd);
    expectReg("ovf sticky", icc_pkg::OFF_CTRL, c | 32'h10);
    disable_ch();
    expectReg("ovf gone", icc_pkg::OFF_CTRL, 32'h0);
    busWrite(icc_pkg::OFF_ISTAT, 32'h3);
    busWrite(icc_pkg::OFF_IMASK, 32'h0);
    // disabled channel ignores edges but keeps configuration
    c = ctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, icc_pkg::MODE_ANY);
    busWrite(icc_pkg::OFF_CTRL, c);
    toggle();
    expectReg("off no cap", icc_pkg::OFF_CTRL, c);
    expectReg("off no evt", icc_pkg::OFF_ISTAT, 32'h0);
    // idle halt on and off
    c = ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 2'h0, icc_pkg::MODE_ANY);
    busWrite(icc_pkg::OFF_CTRL, c);
    idleMode <= 1'b1;
    toggle();
    expectReg("idle halt", icc_pkg::OFF_CTRL, c);
    c = ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, icc_pkg::MODE_ANY);
    busWrite(icc_pkg::OFF_CTRL, c);
    toggle();
    expectReg("idle run", icc_pkg::OFF_CTRL, c | 32'h8);
    @(posedge core_clk);
    idleMode <= 1'b0;
    disable_ch();
    // prescaled mode: only every fourth rising edge is captured
    c = ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, icc_pkg::MODE_RISE4);
    busWrite(icc_pkg::OFF_CTRL, c);
    for (e = 0; e < 6; e++) toggle();
    expectReg("presc wait", icc_pkg::OFF_CTRL, c);
    for (e = 0; e < 2; e++) toggle();
    expectReg("presc hit", icc_pkg::OFF_CTRL, c | 32'h8);
    expectReg("presc val", icc_pkg::OFF_BUF, 32'h0000_abcd);
    for (e = 0; e < 8; e++) toggle();
    expectReg("presc again", icc_pkg::OFF_CTRL, c | 32'h8);
    disable_ch();
    wrapUp();
  end
endmodule : input_capture_control_tb_top
